// ---- hw/bcd_arith_pkg.sv ----
// Constants, types and register map of the BCD convert and arithmetic unit
`default_nettype none

package bcd_arith_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRC1_LO = 8'h04;
  localparam logic [7:0] ADDR_SRC1_HI = 8'h08;
  localparam logic [7:0] ADDR_SRC2_LO = 8'h0C;
  localparam logic [7:0] ADDR_SRC2_HI = 8'h10;
  localparam logic [7:0] ADDR_DEST0 = 8'h14;
  localparam logic [7:0] ADDR_DEST1 = 8'h18;
  localparam logic [7:0] ADDR_DEST2 = 8'h1C;
  localparam logic [7:0] ADDR_DEST3 = 8'h20;
  localparam logic [7:0] ADDR_FLAGS = 8'h24;
  localparam logic [7:0] ADDR_ERR_CODE = 8'h28;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_INT_MASK = 8'h30;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_WIDE_BIT = 2;
  localparam int CTRL_PULSE_BIT = 3;
  localparam int CTRL_DEST_SRC_BIT = 4;
  localparam int FLAG_ZERO_BIT = 0;
  localparam int FLAG_BORROW_BIT = 1;
  localparam int FLAG_CARRY_BIT = 2;
  localparam int FLAG_ERROR_BIT = 3;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ERROR_BIT = 1;
  localparam int INT_CARRY_BIT = 2;
  localparam int INT_BORROW_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [3:0] INT_MASK_RESET = 4'h0;
  localparam logic [15:0] ERR_CODE_RESET = 16'h0000;
  // Code written on an invalid BCD source; value is arbitrary
  localparam logic [15:0] ERR_CODE_BAD_BCD = 16'h0001;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic signed [33:0] MAX16 = 34'sh0_0000_7FFF;
  localparam logic signed [33:0] MIN16 = -34'sh0_0000_8000;
  localparam logic signed [33:0] MAX32 = 34'sh0_7FFF_FFFF;
  localparam logic signed [33:0] MIN32 = -34'sh0_8000_0000;

  typedef enum logic [1:0] {
    OP_BCD2BIN = 2'b00,
    OP_ADD = 2'b01,
    OP_SUB = 2'b10,
    OP_MUL = 2'b11
  } op_e;

endpackage : bcd_arith_pkg

`default_nettype wire

// ---- hw/bcd_arith_unit.sv ----
// BCD to binary converter and signed add, subtract, multiply engine with APB registers
//
// Notes on behaviour
// - Convert BCD source (four or eight digits) to binary, write to destination.
// - Bad BCD digit sets error flag, writes error code, destination kept.
// - Add the two sources as signed values into the destination.
// - Top bit of each operand is the sign; arithmetic is algebraic.
// - Add or subtract giving zero sets the zero flag.
// - Result below most negative value sets the borrow flag.
// - Result above most positive value sets the carry flag.
// - Wide operand: named word is low half, next word is high half.
// - Continuous form repeats the operation every scan while enabled.
// - Pulse form runs once on the scan where enable rises.
// - Subtract second source from first as signed values into destination.
// - Subtraction flags, pairing and execution forms match addition.
// - Multiply the two sources as signed values into destination.
// - Narrow product is 32 bits: low half to named word, high next.
// - Wide product is 64 bits over four consecutive words.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`default_nettype none

module bcd_arith_unit (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_input,
  input wire logic scan_strobe,
  output logic zero_result_flag,
  output logic borrow_result_flag,
  output logic carry_result_flag,
  output logic operation_error_flag,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [4:0] ctrl;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [63:0] dest;
    logic zero;
    logic borrow;
    logic carry;
    logic op_err;
    logic [15:0] err_code;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic irq;
    logic [2:0] en_sync;
    logic en_level;
    logic en_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s cur;
  state_s next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // BCD helpers

  function automatic logic [31:0] bcd_value(input logic [31:0] v, input logic wide);
    logic [31:0] acc;
    acc = 32'h0000_0000;
    for (int i = 7; i >= 0; i--) begin
      if (wide || i < 4) begin
        acc = (acc << 3) + (acc << 1) + {28'h000_0000, v[i*4 +: 4]};
      end
    end
    return acc;
  endfunction : bcd_value

  function automatic logic bcd_bad(input logic [31:0] v, input logic wide);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if ((wide || i < 4) && v[i*4 +: 4] > bcd_arith_pkg::BCD_DIGIT_MAX) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction : bcd_bad

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  bcd_arith_pkg::op_e op;
  logic wide;
  logic pulse_mode;
  logic dest_src;
  logic [31:0] opa;
  logic signed [33:0] a_s;
  logic signed [33:0] b_s;
  logic signed [33:0] sum;
  logic signed [63:0] prod;
  logic [31:0] bcd_bin;
  logic bad_digit;
  logic res_zero;
  logic res_carry;
  logic res_borrow;

  always_comb begin
    op = bcd_arith_pkg::op_e'(cur.ctrl[bcd_arith_pkg::CTRL_OP_LSB +: 2]);
    wide = cur.ctrl[bcd_arith_pkg::CTRL_WIDE_BIT];
    pulse_mode = cur.ctrl[bcd_arith_pkg::CTRL_PULSE_BIT];
    dest_src = cur.ctrl[bcd_arith_pkg::CTRL_DEST_SRC_BIT];
    // Destination fed back as first source: value moves on every fire
    opa = dest_src ? cur.dest[31:0] : cur.src1;
    // Sign extend from bit 15 or bit 31
    if (wide) begin
      a_s = {{2{opa[31]}}, opa};
      b_s = {{2{cur.src2[31]}}, cur.src2};
    end else begin
      a_s = {{18{opa[15]}}, opa[15:0]};
      b_s = {{18{cur.src2[15]}}, cur.src2[15:0]};
    end
    if (op == bcd_arith_pkg::OP_SUB) begin
      sum = a_s - b_s;
    end else begin
      sum = a_s + b_s;
    end
    prod = $signed(a_s[31:0]) * $signed(b_s[31:0]);
    bcd_bin = bcd_value(opa, wide);
    bad_digit = bcd_bad(opa, wide);
    res_zero = (sum == 34'sh0_0000_0000);
    if (wide) begin
      res_carry = (sum > bcd_arith_pkg::MAX32);
      res_borrow = (sum < bcd_arith_pkg::MIN32);
    end else begin
      res_carry = (sum > bcd_arith_pkg::MAX16);
      res_borrow = (sum < bcd_arith_pkg::MIN16);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic fire;
  logic wr;
  logic rd_setup;
  logic mapped;
  logic [3:0] events;
  logic [3:0] status_clr;
  logic err_clr;
  logic [31:0] rdata;

  always_comb begin
    next_cur = cur;
    events = 4'h0;
    status_clr = 4'h0;
    err_clr = 1'b0;

    // Enable pin: three stages, level accepted once stages two and three agree
    next_cur.en_sync = {cur.en_sync[1:0], enable_input};
    if (cur.en_sync[1] == cur.en_sync[2]) begin
      next_cur.en_level = cur.en_sync[2];
    end

    // Continuous runs every enabled scan, pulse only on the rising scan
    fire = scan_strobe && cur.en_level && (!pulse_mode || !cur.en_prev);
    if (scan_strobe) begin
      next_cur.en_prev = cur.en_level;
    end

    // Nothing moves unless fire; failed conversion writes no result
    if (fire) begin
      case (op)
        bcd_arith_pkg::OP_BCD2BIN: begin
          if (bad_digit) begin
            next_cur.op_err = 1'b1;
            next_cur.err_code = bcd_arith_pkg::ERR_CODE_BAD_BCD;
            events[bcd_arith_pkg::INT_ERROR_BIT] = 1'b1;
          end else if (wide) begin
            next_cur.dest[31:0] = bcd_bin;
            events[bcd_arith_pkg::INT_DONE_BIT] = 1'b1;
          end else begin
            next_cur.dest[15:0] = bcd_bin[15:0];
            events[bcd_arith_pkg::INT_DONE_BIT] = 1'b1;
          end
        end
        bcd_arith_pkg::OP_ADD, bcd_arith_pkg::OP_SUB: begin
          // Same path for both, so flags and pairing cannot drift apart
          if (wide) begin
            next_cur.dest[31:0] = sum[31:0];
          end else begin
            next_cur.dest[15:0] = sum[15:0];
          end
          next_cur.zero = res_zero;
          next_cur.carry = res_carry;
          next_cur.borrow = res_borrow;
          events[bcd_arith_pkg::INT_DONE_BIT] = 1'b1;
          events[bcd_arith_pkg::INT_CARRY_BIT] = res_carry;
          events[bcd_arith_pkg::INT_BORROW_BIT] = res_borrow;
        end
        bcd_arith_pkg::OP_MUL: begin
          if (wide) begin
            next_cur.dest = prod;
          end else begin
            next_cur.dest[31:0] = prod[31:0];
          end
          events[bcd_arith_pkg::INT_DONE_BIT] = 1'b1;
        end
        default: begin
          next_cur.dest = cur.dest;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access phase, pready from a flip-flop

    wr = psel && penable && pwrite && cur.pready;
    rd_setup = psel && !penable;
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      bcd_arith_pkg::ADDR_CTRL: rdata = {27'h000_0000, cur.ctrl};
      bcd_arith_pkg::ADDR_SRC1_LO: rdata = {16'h0000, cur.src1[15:0]};
      bcd_arith_pkg::ADDR_SRC1_HI: rdata = {16'h0000, cur.src1[31:16]};
      bcd_arith_pkg::ADDR_SRC2_LO: rdata = {16'h0000, cur.src2[15:0]};
      bcd_arith_pkg::ADDR_SRC2_HI: rdata = {16'h0000, cur.src2[31:16]};
      bcd_arith_pkg::ADDR_DEST0: rdata = {16'h0000, cur.dest[15:0]};
      bcd_arith_pkg::ADDR_DEST1: rdata = {16'h0000, cur.dest[31:16]};
      bcd_arith_pkg::ADDR_DEST2: rdata = {16'h0000, cur.dest[47:32]};
      bcd_arith_pkg::ADDR_DEST3: rdata = {16'h0000, cur.dest[63:48]};
      bcd_arith_pkg::ADDR_FLAGS: rdata = {28'h000_0000, cur.op_err, cur.carry, cur.borrow,
                                          cur.zero};
      bcd_arith_pkg::ADDR_ERR_CODE: rdata = {16'h0000, cur.err_code};
      bcd_arith_pkg::ADDR_INT_STATUS: rdata = {28'h000_0000, cur.int_status};
      bcd_arith_pkg::ADDR_INT_MASK: rdata = {28'h000_0000, cur.int_mask};
      default: mapped = 1'b0;
    endcase

    next_cur.pready = rd_setup;
    if (rd_setup) begin
      next_cur.prdata = pwrite ? 32'h0000_0000 : rdata;
      next_cur.pslverr = !mapped;
    end else begin
      next_cur.prdata = 32'h0000_0000;
      next_cur.pslverr = 1'b0;
    end

    // Destination words are read-only; the engine is their only writer
    if (wr) begin
      case (paddr)
        bcd_arith_pkg::ADDR_CTRL: next_cur.ctrl = pwdata[4:0];
        bcd_arith_pkg::ADDR_SRC1_LO: next_cur.src1[15:0] = pwdata[15:0];
        bcd_arith_pkg::ADDR_SRC1_HI: next_cur.src1[31:16] = pwdata[15:0];
        bcd_arith_pkg::ADDR_SRC2_LO: next_cur.src2[15:0] = pwdata[15:0];
        bcd_arith_pkg::ADDR_SRC2_HI: next_cur.src2[31:16] = pwdata[15:0];
        bcd_arith_pkg::ADDR_FLAGS: err_clr = pwdata[bcd_arith_pkg::FLAG_ERROR_BIT];
        bcd_arith_pkg::ADDR_INT_STATUS: status_clr = pwdata[3:0];
        bcd_arith_pkg::ADDR_INT_MASK: next_cur.int_mask = pwdata[3:0];
        default: next_cur.ctrl = cur.ctrl;
      endcase
    end

    // Set beats clear, so an error in the clearing cycle stays visible
    if (err_clr && !events[bcd_arith_pkg::INT_ERROR_BIT]) begin
      next_cur.op_err = 1'b0;
    end
    next_cur.int_status = (cur.int_status & ~status_clr) | events;
    next_cur.irq = |(next_cur.int_status & cur.int_mask);
    if (wr && paddr == bcd_arith_pkg::ADDR_INT_MASK) begin
      next_cur.irq = |(next_cur.int_status & pwdata[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock) begin
    if (srst) begin
      cur <= '0;
      cur.ctrl <= bcd_arith_pkg::CTRL_RESET;
      cur.int_mask <= bcd_arith_pkg::INT_MASK_RESET;
      cur.err_code <= bcd_arith_pkg::ERR_CODE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign zero_result_flag = cur.zero;
  assign borrow_result_flag = cur.borrow;
  assign carry_result_flag = cur.carry;
  assign operation_error_flag = cur.op_err;
  assign irq = cur.irq;

endmodule : bcd_arith_unit

`default_nettype wire

// ---- bench/bcd_arith_checker_assertions.sv ----
// Port-level checker for the BCD convert and arithmetic unit
`default_nettype none
module bcd_arith_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scan_strobe,
  input wire logic zero_result_flag,
  input wire logic borrow_result_flag,
  input wire logic carry_result_flag,
  input wire logic operation_error_flag
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  a_ready_in_access: assert property (setup_s ##1 access_s |-> pready)
    else $error("pready missing in access");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not idle");
  // Flags move only on a scan edge
  a_flags_hold: assert property (!scan_strobe |=>
    $stable({zero_result_flag, borrow_result_flag, carry_result_flag}))
    else $error("flags moved without scan");
  a_flags_exclusive: assert property (
    $onehot0({zero_result_flag, borrow_result_flag, carry_result_flag}))
    else $error("flags not exclusive");
  a_err_sticky: assert property (operation_error_flag &&
    !(psel && penable && pready && pwrite) |=> operation_error_flag)
    else $error("error flag dropped");
  a_err_on_scan: assert property ($rose(operation_error_flag) |-> $past(scan_strobe))
    else $error("error flag without scan");
endmodule : bcd_arith_checker
bind bcd_arith_unit bcd_arith_checker chk_u (.clock(clock), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scan_strobe(scan_strobe), .zero_result_flag(zero_result_flag),
  .borrow_result_flag(borrow_result_flag), .carry_result_flag(carry_result_flag),
  .operation_error_flag(operation_error_flag));
`default_nettype wire

// ---- bench/scan_sequencer.sv ----
// Controller scan model: issues a burst of program scan strobes
`default_nettype none
module scan_sequencer (
  input wire logic clock,
  input wire logic srst,
  input wire logic go,
  input wire logic [3:0] count,
  output logic scan_strobe,
  output logic busy
);
  logic [3:0] left;
  // Strobes spaced two cycles so each scan is a separate fire
  always_ff @(posedge clock) begin
    if (srst) begin
      left <= 4'h0;
      scan_strobe <= 1'b0;
    end else begin
      if (go) begin
        left <= count;
      end else if (left != 4'h0 && !scan_strobe) begin
        left <= left - 4'h1;
      end
      scan_strobe <= !go && left != 4'h0 && !scan_strobe;
    end
  end
  assign busy = left != 4'h0 || scan_strobe;
endmodule : scan_sequencer
`default_nettype wire

// ---- bench/bcd_arith_unit_tb.sv ----
// Self-checking bench for the BCD convert and arithmetic unit
`default_nettype none
module bcd_arith_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] op; logic w; logic [31:0] a, b; logic [63:0] x;
    int n; logic [3:0] f;} row_s;
  logic clock, srst, psel, penable, pwrite, enable_input, go, busy, scan_strobe;
  logic pready, pslverr, zf, bf, cf, ef, irq, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [3:0] cnt;
  int miscompares, num_checks, cycles;
  row_s tbl [10];
  ////////////////////////////////////////////////////////////////////////////
  bcd_arith_unit dut_u (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_input(enable_input), .scan_strobe(scan_strobe),
    .zero_result_flag(zf), .borrow_result_flag(bf), .carry_result_flag(cf),
    .operation_error_flag(ef), .irq(irq));
  scan_sequencer seq_u (.clock(clock), .srst(srst), .go(go), .count(cnt),
    .scan_strobe(scan_strobe), .busy(busy));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Holds the request until pready is seen, then idles one cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No local limit: a missing pready runs into the cycle ceiling
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rq, exp);
  endtask : rc
  task scans(input logic [3:0] n);
    go <= 1'b1;
    cnt <= n;
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
    end while (busy !== 1'b0);
  endtask : scans
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst <= 1'b1;
    {psel, penable, pwrite, enable_input, go} <= 5'h00;
    cnt <= 4'h0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    tbl[0] = '{2'h0, 1'b0, 32'h0000_1234, 32'h0, 64'h0000_0000_0000_04D2, 1, 4'h0};
    tbl[1] = '{2'h0, 1'b1, 32'h1234_5678, 32'h0, 64'h0000_0000_00BC_614E, 2, 4'h0};
    tbl[2] = '{2'h0, 1'b0, 32'h0000_12A4, 32'h0, 64'h0000_0000_0000_614E, 1, 4'h8};
    tbl[3] = '{2'h1, 1'b0, 32'h0000_0005, 32'h0000_FFF8, 64'h0000_FFFD, 1, 4'h8};
    tbl[4] = '{2'h1, 1'b0, 32'h0000_7FFF, 32'h0000_0001, 64'h0000_8000, 1, 4'hC};
    tbl[5] = '{2'h2, 1'b0, 32'h0000_8000, 32'h0000_0001, 64'h0000_7FFF, 1, 4'hA};
    tbl[6] = '{2'h2, 1'b0, 32'h0000_0005, 32'h0000_0005, 64'h0000_0000, 1, 4'h9};
    tbl[7] = '{2'h1, 1'b1, 32'h7FFF_FFFF, 32'h0000_0001, 64'h8000_0000, 2, 4'hC};
    tbl[8] = '{2'h3, 1'b0, 32'h0000_FFFD, 32'h0000_0004, 64'hFFFF_FFF4, 2, 4'hC};
    tbl[9] = '{2'h3, 1'b1, 32'hFFFF_FFFE, 32'h0000_0003, 64'hFFFF_FFFF_FFFF_FFFA, 4, 4'hC};
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rc("flags", bcd_arith_pkg::ADDR_FLAGS, 32'h0000_0000);
    rc("unmapped", 8'h34, 32'h0000_0000);
    chk("slverr", {31'h0, re}, 32'h0000_0001);
    $display("test reset done");
    enable_input <= 1'b1;
    repeat (5) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      wr(bcd_arith_pkg::ADDR_SRC1_LO, {16'h0, tbl[i].a[15:0]});
      wr(bcd_arith_pkg::ADDR_SRC1_HI, {16'h0, tbl[i].a[31:16]});
      wr(bcd_arith_pkg::ADDR_SRC2_LO, {16'h0, tbl[i].b[15:0]});
      wr(bcd_arith_pkg::ADDR_SRC2_HI, {16'h0, tbl[i].b[31:16]});
      wr(bcd_arith_pkg::ADDR_CTRL, {29'h0, tbl[i].w, tbl[i].op});
      scans(4'h1);
      for (int k = 0; k < tbl[i].n; k++) begin
        rc("dest", bcd_arith_pkg::ADDR_DEST0 + 8'(4 * k),
          {16'h0, tbl[i].x[16 * k +: 16]});
      end
      rc("flags", bcd_arith_pkg::ADDR_FLAGS, {28'h0, tbl[i].f});
      chk("flag pins", {28'h0, ef, cf, bf, zf}, {28'h0, tbl[i].f});
      $display("test row %0d done", i);
    end
    rc("errcode", bcd_arith_pkg::ADDR_ERR_CODE, {16'h0, bcd_arith_pkg::ERR_CODE_BAD_BCD});
    wr(bcd_arith_pkg::ADDR_SRC2_LO, 32'h0000_0001);
    wr(bcd_arith_pkg::ADDR_CTRL, 32'h0000_0011);
    scans(4'h3);
    rc("continuous", bcd_arith_pkg::ADDR_DEST0, 32'h0000_FFFD);
    wr(bcd_arith_pkg::ADDR_CTRL, 32'h0000_0019);
    scans(4'h3);
    rc("pulse held", bcd_arith_pkg::ADDR_DEST0, 32'h0000_FFFD);
    enable_input <= 1'b0;
    repeat (5) @(posedge clock);
    // Continuous form here, so only the enable gate can hold the result
    wr(bcd_arith_pkg::ADDR_CTRL, 32'h0000_0011);
    scans(4'h1);
    rc("disabled", bcd_arith_pkg::ADDR_DEST0, 32'h0000_FFFD);
    wr(bcd_arith_pkg::ADDR_CTRL, 32'h0000_0019);
    enable_input <= 1'b1;
    repeat (5) @(posedge clock);
    scans(4'h3);
    rc("pulse edge", bcd_arith_pkg::ADDR_DEST0, 32'h0000_FFFE);
    $display("test scan forms done");
    rc("status", bcd_arith_pkg::ADDR_INT_STATUS, 32'h0000_000F);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(bcd_arith_pkg::ADDR_INT_MASK, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk("irq set", {31'h0, irq}, 32'h0000_0001);
    wr(bcd_arith_pkg::ADDR_INT_STATUS, 32'h0000_000F);
    wr(bcd_arith_pkg::ADDR_FLAGS, 32'h0000_0008);
    repeat (2) @(posedge clock);
    chk("irq clear", {31'h0, irq}, 32'h0000_0000);
    chk("error clear", {31'h0, ef}, 32'h0000_0000);
    rc("status clear", bcd_arith_pkg::ADDR_INT_STATUS, 32'h0000_0000);
    $display("test interrupts done");
    report_and_stop();
  end
endmodule : bcd_arith_unit_tb
`default_nettype wire
